// ### verilog/sep_i2c_slave.sv
`timescale 1ns/1ps
// Operation
// - Start opens, stop closes; bytes acknowledged
// - Start is SDA falling while SCL high
// - Watch for start always; none, no command
// - Stop is SDA rising while SCL high
// - Transmitter releases; receiver pulls ninth bit low
// - Matching address byte gets low acknowledge
// - Acknowledge every word address and data byte
// - Keep sending bytes while master acknowledges
// - No acknowledge: stop sending, await stop
// - Upper four address bits match type code
// - Three select bits match strapped pins
// - Lowest address bit: zero write, one read
// - Page select bits replace some select bits
// - Byte write or page write up to limit
// - Small pages: low three/four bits increment
// - Large page: low five bits increment
// - Overlong page wraps and overwrites from start
// - Short page writes only received bytes
// - Whole page programs within one write time
// - Ignore commands, no acknowledge while writing
// - Write protect high blocks every write
module sep_i2c_slave import sep_pkg::*; #(
	parameter int unsigned TWR_CYC = TWR_CYC_DEF,
	parameter logic [3:0] DEV_TYPE = DEV_TYPE_DEF
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic scl,
	input wire logic sda_pin,
	output logic sda_drv,
	output logic sda_oe,
	input wire logic write_protect,
	input wire logic device_select_bit0,
	input wire logic device_select_bit1,
	input wire logic device_select_bit2,
	input wire logic [1:0] cfg_page_size,
	input wire logic cfg_wide_addr,
	input wire logic [1:0] cfg_page_sel_cnt,
	output logic write_busy
);

	// ****************************************
	// Storage
	// ****************************************
	logic [7:0] mem [MEM_WORDS];
	logic [7:0] pbuf [PAGE_BUF_N];

	// ****************************************
	// Reset and pin synchronisers (system clock)
	// ****************************************
	logic rs1_r, rst_n_r;
	logic scl_s1_r, scl_s2_r, scl_s3_r;
	logic sda_s1_r, sda_s2_r, sda_s3_r;
	logic wp_s1_r, wp_s2_r;
	logic wrq_s1_r, wrq_s2_r, wreq_r, wreq_nxt;
	logic link_rstn_r, link_rstn_nxt, frm_r, frm_nxt;
	logic start_det, stop_det;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rs1_r <= 1'b0;
			rst_n_r <= 1'b0;
		end else begin
			rs1_r <= 1'b1;
			rst_n_r <= rs1_r;
		end
	end

	always_ff @(posedge clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			scl_s1_r <= 1'b1;
			scl_s2_r <= 1'b1;
			scl_s3_r <= 1'b1;
			sda_s1_r <= 1'b1;
			sda_s2_r <= 1'b1;
			sda_s3_r <= 1'b1;
			wp_s1_r <= 1'b0;
			wp_s2_r <= 1'b0;
			wrq_s1_r <= 1'b0;
			wrq_s2_r <= 1'b0;
			link_rstn_r <= 1'b0;
			frm_r <= 1'b0;
		end else begin
			scl_s1_r <= scl;
			scl_s2_r <= scl_s1_r;
			scl_s3_r <= scl_s2_r;
			sda_s1_r <= sda_pin;
			sda_s2_r <= sda_s1_r;
			sda_s3_r <= sda_s2_r;
			wp_s1_r <= write_protect;
			wp_s2_r <= wp_s1_r;
			wrq_s1_r <= wreq_r;
			wrq_s2_r <= wrq_s1_r;
			link_rstn_r <= link_rstn_nxt;
			frm_r <= frm_nxt;
		end
	end

	// ****************************************
	// Start and stop detection
	// ****************************************
	// SCL holds no edge across these, so the system clock watches the lines
	always_comb begin
		start_det = scl_s2_r & scl_s3_r & sda_s3_r & ~sda_s2_r;
		stop_det = scl_s2_r & scl_s3_r & ~sda_s3_r & sda_s2_r;
		frm_nxt = (frm_r | start_det) & ~stop_det;
		// Engine stays in reset between frames, so stray clocks run no command
		link_rstn_nxt = frm_r & ~start_det & ~stop_det;
	end

	// ****************************************
	// Link engine (SCL domain)
	// ****************************************
	sep_lst_t st_r, st_nxt;
	logic [3:0] cnt_r, cnt_nxt;
	logic [6:0] sr_r, sr_nxt;
	logic ack_r, ack_nxt, rw_r, rw_nxt;
	logic [7:0] hi_r, hi_nxt, rd_r, rd_nxt;
	logic [2:0] psel_r, psel_nxt;
	logic [MEM_AW-1:0] addr_r, addr_nxt, base_r, base_nxt;
	logic [PAGE_BUF_N-1:0] pmask_r, pmask_nxt;
	logic [2:0] ds1_r, ds2_r;
	logic bsy1_r, bsy2_r;
	logic oe_r, oe_nxt;
	logic pb_we;
	logic [7:0] byte_in;
	logic [4:0] pm;
	logic [2:0] psm;
	logic busy_r, busy_nxt;

	always_comb begin
		byte_in = {sr_r, sda_pin};
		pm = page_mask(cfg_page_size);
		psm = cfg_wide_addr ? 3'h0 : psel_mask(cfg_page_sel_cnt);
		st_nxt = st_r;
		cnt_nxt = (cnt_r == BIT_ACK) ? 4'h0 : cnt_r + 4'h1;
		sr_nxt = {sr_r[5:0], sda_pin};
		ack_nxt = ack_r;
		rw_nxt = rw_r;
		hi_nxt = hi_r;
		rd_nxt = rd_r;
		psel_nxt = psel_r;
		addr_nxt = addr_r;
		base_nxt = base_r;
		wreq_nxt = wreq_r;
		pmask_nxt = pmask_r;
		pb_we = 1'b0;
		if (cnt_r == BIT_LAST) begin
			ack_nxt = 1'b0;
			case (st_r)
				ST_ADDR: begin
					// Any new address drops data that no stop committed
					wreq_nxt = 1'b0;
					if (byte_in[7:4] == DEV_TYPE && ((byte_in[3:1] ^ ds2_r) & ~psm) == 3'h0
						&& !bsy2_r) begin
						ack_nxt = 1'b1;
						rw_nxt = byte_in[0];
						psel_nxt = byte_in[3:1] & psm;
					end else begin
						st_nxt = ST_IGN;
					end
				end
				ST_WA_HI: begin
					hi_nxt = byte_in;
					ack_nxt = 1'b1;
				end
				ST_WA_LO: begin
					if (cfg_wide_addr) begin
						addr_nxt = {hi_r[4:0], byte_in};
					end else begin
						addr_nxt = {2'h0, psel_r, byte_in};
					end
					base_nxt = addr_nxt;
					pmask_nxt = '0;
					ack_nxt = 1'b1;
				end
				ST_WD: begin
					pb_we = 1'b1;
					pmask_nxt[addr_r[4:0]] = 1'b1;
					wreq_nxt = 1'b1;
					addr_nxt = (addr_r & ~{8'h00, pm}) | {8'h00, (addr_r[4:0] + 5'h01) & pm};
					ack_nxt = 1'b1;
				end
				default: begin
				end
			endcase
		end else if (cnt_r == BIT_ACK) begin
			ack_nxt = 1'b0;
			case (st_r)
				ST_ADDR: begin
					if (rw_r) begin
						st_nxt = ST_RD;
						rd_nxt = mem[addr_r];
						addr_nxt = addr_r + 13'h0001;
					end else begin
						st_nxt = cfg_wide_addr ? ST_WA_HI : ST_WA_LO;
					end
				end
				ST_WA_HI: st_nxt = ST_WA_LO;
				ST_WA_LO: st_nxt = ST_WD;
				ST_RD: begin
					if (!sda_pin) begin
						rd_nxt = mem[addr_r];
						addr_nxt = addr_r + 13'h0001;
					end else begin
						st_nxt = ST_IGN;
					end
				end
				default: begin
				end
			endcase
		end
	end

	// Memory contents only change while busy, and busy refuses every command,
	// so the engine reads a stable array.
	always_ff @(posedge scl or negedge link_rstn_r) begin
		if (!link_rstn_r) begin
			st_r <= ST_ADDR;
			cnt_r <= 4'h0;
			sr_r <= 7'h00;
			ack_r <= 1'b0;
			rw_r <= 1'b0;
			hi_r <= 8'h00;
			rd_r <= 8'hFF;
			psel_r <= 3'h0;
		end else begin
			st_r <= st_nxt;
			cnt_r <= cnt_nxt;
			sr_r <= sr_nxt;
			ack_r <= ack_nxt;
			rw_r <= rw_nxt;
			hi_r <= hi_nxt;
			rd_r <= rd_nxt;
			psel_r <= psel_nxt;
		end
	end

	always_ff @(posedge scl or negedge rst_n_r) begin
		if (!rst_n_r) begin
			addr_r <= '0;
			base_r <= '0;
			wreq_r <= 1'b0;
			pmask_r <= '0;
			ds1_r <= 3'h0;
			ds2_r <= 3'h0;
			bsy1_r <= 1'b0;
			bsy2_r <= 1'b0;
		end else begin
			addr_r <= addr_nxt;
			base_r <= base_nxt;
			wreq_r <= wreq_nxt;
			pmask_r <= pmask_nxt;
			ds1_r <= {device_select_bit2, device_select_bit1, device_select_bit0};
			ds2_r <= ds1_r;
			bsy1_r <= busy_r;
			bsy2_r <= bsy1_r;
		end
	end

	always_ff @(posedge scl) begin
		if (pb_we) begin
			pbuf[addr_r[4:0]] <= byte_in;
		end
	end

	// SDA changes only while SCL is low
	always_comb begin
		oe_nxt = 1'b0;
		if (cnt_r == BIT_ACK) begin
			oe_nxt = ack_r && st_r != ST_RD;
		end else if (st_r == ST_RD) begin
			oe_nxt = ~rd_r[3'(BIT_LAST - cnt_r)];
		end
	end

	always_ff @(negedge scl or negedge link_rstn_r) begin
		if (!link_rstn_r) begin
			oe_r <= 1'b0;
		end else begin
			oe_r <= oe_nxt;
		end
	end

	assign sda_oe = oe_r;
	assign sda_drv = 1'b0;

	// ****************************************
	// Internal write (system clock)
	// ****************************************
	sep_bst_t bst_r, bst_nxt;
	logic [PAGE_IDX_W-1:0] idx_r, idx_nxt;
	logic [TMR_W-1:0] tmr_r, tmr_nxt;
	logic mem_we;

	// Page buffer and mask are settled before stop, so a level crossing suffices
	always_comb begin
		bst_nxt = bst_r;
		idx_nxt = idx_r;
		tmr_nxt = tmr_r + 24'h000001;
		mem_we = 1'b0;
		case (bst_r)
			BS_IDLE: begin
				tmr_nxt = '0;
				idx_nxt = '0;
				if (stop_det && wrq_s2_r && !wp_s2_r) begin
					bst_nxt = BS_COMMIT;
				end
			end
			BS_COMMIT: begin
				mem_we = pmask_r[idx_r] && !wp_s2_r;
				idx_nxt = idx_r + 5'h01;
				if (wp_s2_r) begin
					bst_nxt = BS_IDLE;
				end else if (idx_r == PAGE_IDX_LAST) begin
					bst_nxt = BS_WAIT;
				end
			end
			BS_WAIT: begin
				if (wp_s2_r || tmr_r == TMR_W'(TWR_CYC - 1)) begin
					bst_nxt = BS_IDLE;
				end
			end
			default: bst_nxt = BS_IDLE;
		endcase
		busy_nxt = bst_nxt != BS_IDLE;
	end

	always_ff @(posedge clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			bst_r <= BS_IDLE;
			idx_r <= '0;
			tmr_r <= '0;
			busy_r <= 1'b0;
		end else begin
			bst_r <= bst_nxt;
			idx_r <= idx_nxt;
			tmr_r <= tmr_nxt;
			busy_r <= busy_nxt;
		end
	end

	always_ff @(posedge clk) begin
		if (mem_we) begin
			mem[{base_r[MEM_AW-1:5], idx_r}] <= pbuf[idx_r];
		end
	end

	assign write_busy = busy_r;

	// ****************************************
	// Assertions
	// ****************************************
	AST_ADDR_ACK: assert property (
		@(posedge scl) disable iff (!link_rstn_r)
		(st_r == ST_ADDR && cnt_r == BIT_LAST && byte_in[7:4] == DEV_TYPE
		&& ((byte_in[3:1] ^ ds2_r) & ~psm) == 3'h0 && !bsy2_r) |=> ack_r
	) else $error("matching address not acknowledged");

	AST_TYPE_MISS: assert property (
		@(posedge scl) disable iff (!link_rstn_r)
		(st_r == ST_ADDR && cnt_r == BIT_LAST && byte_in[7:4] != DEV_TYPE)
		|=> (st_r == ST_IGN && !ack_r)
	) else $error("foreign type code answered");

	AST_BUSY_NACK: assert property (
		@(posedge scl) disable iff (!link_rstn_r)
		(st_r == ST_ADDR && cnt_r == BIT_LAST && bsy2_r) |=> !sda_oe
	) else $error("acknowledge given while writing");

	AST_WR_ACK: assert property (
		@(posedge scl) disable iff (!link_rstn_r)
		(st_r == ST_WD && cnt_r == BIT_LAST) |=> (ack_r && cnt_r == BIT_ACK)
	) else $error("write byte not acknowledged");

	AST_PAGE_WRAP: assert property (
		@(posedge scl) disable iff (!link_rstn_r)
		(st_r == ST_WD && cnt_r == BIT_LAST) |=>
		((addr_r & ~{8'h00, pm}) == ($past(addr_r) & ~{8'h00, pm}))
	) else $error("page write left its page");

	AST_RD_NEXT: assert property (
		@(posedge scl) disable iff (!link_rstn_r)
		(st_r == ST_RD && cnt_r == BIT_ACK && !sda_pin) |=>
		(st_r == ST_RD && addr_r == $past(addr_r) + 13'h0001)
	) else $error("read did not continue after acknowledge");

	AST_RD_END: assert property (
		@(posedge scl) disable iff (!link_rstn_r)
		(st_r == ST_RD && cnt_r == BIT_ACK && sda_pin) |=> (st_r == ST_IGN) [*3]
	) else $error("read continued after no acknowledge");

	AST_SDA_SLOT: assert property (
		@(posedge scl) disable iff (!link_rstn_r)
		sda_oe |-> (cnt_r == BIT_ACK || st_r == ST_RD)
	) else $error("SDA driven outside own slot");

	AST_WP_BLOCK: assert property (
		@(posedge clk) disable iff (!rst_n_r)
		(bst_r == BS_IDLE && stop_det && wp_s2_r) |=> (bst_r == BS_IDLE && !mem_we)
	) else $error("write started while protected");

	AST_TWR_BOUND: assert property (
		@(posedge clk) disable iff (!rst_n_r)
		(bst_r != BS_IDLE) |-> (tmr_r < TMR_W'(TWR_CYC))
	) else $error("internal write exceeded its time");

	AST_START_CLR: assert property (
		@(posedge clk) disable iff (!rst_n_r)
		start_det |=> !link_rstn_r ##1 link_rstn_r
	) else $error("start did not restart the engine");

endmodule : sep_i2c_slave

// ### verilog/sep_pkg.sv
package sep_pkg;

	// ****************************************
	// Timing
	// ****************************************
	localparam int unsigned CLK_FREQ_HZ = 25000000;
	localparam int unsigned TWR_MS = 5;
	localparam int unsigned TWR_CYC_DEF = TWR_MS * (CLK_FREQ_HZ / 1000);
	localparam int unsigned TMR_W = 24;

	// ****************************************
	// Geometry and field positions
	// ****************************************
	localparam int unsigned MEM_AW = 13;
	localparam int unsigned MEM_WORDS = 8192;
	localparam int unsigned PAGE_BUF_N = 32;
	localparam int unsigned PAGE_IDX_W = 5;
	localparam logic [3:0] BIT_LAST = 4'h7;
	localparam logic [3:0] BIT_ACK = 4'h8;
	localparam logic [4:0] PAGE_IDX_LAST = 5'h1F;

	// Type code; value is arbitrary
	localparam logic [3:0] DEV_TYPE_DEF = 4'h6;

	// ****************************************
	// Page size codes and page masks
	// ****************************************
	localparam logic [1:0] PG_8 = 2'h0;
	localparam logic [1:0] PG_16 = 2'h1;
	localparam logic [4:0] PM_8 = 5'h07;
	localparam logic [4:0] PM_16 = 5'h0F;
	localparam logic [4:0] PM_32 = 5'h1F;

	typedef enum logic [2:0] {
		ST_ADDR = 3'h0,
		ST_WA_HI = 3'h1,
		ST_WA_LO = 3'h2,
		ST_WD = 3'h3,
		ST_RD = 3'h4,
		ST_IGN = 3'h5
	} sep_lst_t;

	typedef enum logic [1:0] {
		BS_IDLE = 2'h0,
		BS_COMMIT = 2'h1,
		BS_WAIT = 2'h2
	} sep_bst_t;

	function automatic logic [4:0] page_mask(input logic [1:0] size);
		if (size == PG_8) begin
			page_mask = PM_8;
		end else if (size == PG_16) begin
			page_mask = PM_16;
		end else begin
			page_mask = PM_32;
		end
	endfunction : page_mask

	function automatic logic [2:0] psel_mask(input logic [1:0] cnt);
		// Low select positions turn into page bits first
		psel_mask = 3'((4'h1 << cnt) - 4'h1);
	endfunction : psel_mask

endpackage : sep_pkg

// ### bench/sep_mst_model.sv
`timescale 1ns/1ps
// ****************************************
// Two-wire bus master
// ****************************************
module sep_mst_model (
	output logic scl,
	output logic sda_pull,
	input wire logic sda_line
);
	// Clock stands high between frames; only the master moves it
	initial begin
		scl = 1'b1;
		sda_pull = 1'b0;
	end

	// Start or repeated start: SDA falls while SCL high
	task automatic start();
		#7 sda_pull = 1'b0;
		#40 scl = 1'b1;
		#240 sda_pull = 1'b1;
		#240 scl = 1'b0;
	endtask : start

	// Stop: SDA rises while SCL high, then bus free time
	task automatic stop();
		#20 sda_pull = 1'b1;
		#20 scl = 1'b1;
		#240 sda_pull = 1'b0;
		#240;
	endtask : stop

	// SDA moves only while SCL is low
	task automatic bit_io(input logic b, output logic s);
		// Clocking with no start: drop SCL first so SDA never moves while it is high
		if (scl === 1'b1) begin
			#20 scl = 1'b0;
		end
		#20 sda_pull = ~b;
		#20 scl = 1'b1;
		#20 s = sda_line;
		#20 scl = 1'b0;
	endtask : bit_io

	// Eight bits MSB first, then released for the slave's answer
	task automatic send(input logic [7:0] d, output logic ak);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_io(d[i], s);
		end
		bit_io(1'b1, s);
		ak = ~s;
	endtask : send

	// Low acknowledge asks for more, high ends the read
	task automatic recv(input logic more, output logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_io(1'b1, s);
			d[i] = s;
		end
		bit_io(~more, s);
	endtask : recv
endmodule : sep_mst_model

// ### bench/tb_sep_i2c_slave.sv
`timescale 1ns/1ps
module tb_sep_i2c_slave import sep_pkg::*;;
	localparam int INTERNAL_WRITE_TIME = 200;
	logic clk;
	logic rstn;
	logic write_protect;
	logic device_select_bit0;
	logic device_select_bit1;
	logic device_select_bit2;
	logic [1:0] cfg_page_size;
	logic cfg_wide_addr;
	logic [1:0] cfg_page_sel_cnt;
	logic scl;
	logic sda_pull;
	logic sda_drv;
	logic sda_oe;
	logic write_busy;
	wire logic sda_line;
	int miscompares;
	int comparisons;
	int bcnt;
	int blen;
	logic [7:0] mem [logic [15:0]];

	// Pull-up wins unless some party pulls low
	assign sda_line = ~(sda_pull | (sda_oe & ~sda_drv));

	sep_i2c_slave #(.TWR_CYC(INTERNAL_WRITE_TIME)) DUT (.clk(clk), .rstn(rstn), .scl(scl),
		.sda_pin(sda_line), .sda_drv(sda_drv), .sda_oe(sda_oe),
		.write_protect(write_protect), .device_select_bit0(device_select_bit0),
		.device_select_bit1(device_select_bit1), .device_select_bit2(device_select_bit2),
		.cfg_page_size(cfg_page_size), .cfg_wide_addr(cfg_wide_addr),
		.cfg_page_sel_cnt(cfg_page_sel_cnt), .write_busy(write_busy));

	sep_mst_model m (.scl(scl), .sda_pull(sda_pull), .sda_line(sda_line));

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	// Length of the last busy period
	always @(posedge clk) begin
		if (write_busy === 1'b1) begin
			bcnt <= bcnt + 1;
		end else if (bcnt != 0) begin
			blen <= bcnt;
			bcnt <= 0;
		end
	end

	// ****************************************
	// Helpers
	// ****************************************
	task automatic results();
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : results

	task automatic chk(input logic [7:0] s, input logic [7:0] e);
		comparisons++;
		if (s !== e) begin
			miscompares++;
			$display("FAIL t=%0t seen %h expected %h", $time, s, e);
		end
	endtask : chk

	task automatic sb(input logic [7:0] b, input logic ea);
		logic ak;
		m.send(b, ak);
		chk(ak, ea);
	endtask : sb

	task automatic cfg(input logic [1:0] ps, input logic w, input logic [1:0] pc, input logic p);
		@(negedge clk);
		cfg_page_size = ps;
		cfg_wide_addr = w;
		cfg_page_sel_cnt = pc;
		write_protect = p;
		repeat (4) @(negedge clk);
	endtask : cfg

	task automatic addr(input logic [2:0] sel, input logic [12:0] a);
		m.start();
		sb({DEV_TYPE_DEF, sel, 1'b0}, 1'b1);
		if (cfg_wide_addr) sb({3'h0, a[12:8]}, 1'b1);
		sb(a[7:0], 1'b1);
	endtask : addr

	task automatic wr(input logic [2:0] sel, input logic [12:0] a, input int n,
		input logic [7:0] d0);
		logic [4:0] mk;
		mk = cfg_page_size == 2'h0 ? 5'h07 : cfg_page_size == 2'h1 ? 5'h0F : 5'h1F;
		addr(sel, a);
		for (int i = 0; i < n; i++) begin
			sb(d0 + 8'(i), 1'b1);
			if (write_protect === 1'b0) begin
				mem[{sel, a[12:5], a[4:0] & ~mk | 5'(a[4:0] + i) & mk}] = d0 + 8'(i);
			end
		end
		m.stop();
		chk(write_busy, !write_protect);
		if (write_busy === 1'b1) begin
			m.start();
			sb({DEV_TYPE_DEF, sel, 1'b0}, 1'b0);
			m.stop();
			for (int i = 0; i < 400 && write_busy === 1'b1; i++) @(posedge clk);
			repeat (2) @(posedge clk);
			chk(blen >= INTERNAL_WRITE_TIME - 2 && blen <= INTERNAL_WRITE_TIME + 2, 1'b1);
		end
	endtask : wr

	task automatic rd(input logic [2:0] sel, input logic [12:0] a, input int n, input logic rnd);
		logic [7:0] d;
		if (rnd) addr(sel, a);
		m.start();
		sb({DEV_TYPE_DEF, sel, 1'b1}, 1'b1);
		for (int i = 0; i < n; i++) begin
			m.recv(i < n - 1, d);
			if (mem.exists({sel, 13'(a + i)})) chk(d, mem[{sel, 13'(a + i)}]);
		end
		// After a high acknowledge the slave must stay off the line
		m.recv(1'b0, d);
		chk(d, 8'hFF);
		m.stop();
	endtask : rd

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_decode();
		cfg(2'h0, 1'b0, 2'h0, 1'b0);
		for (int k = 0; k < 8; k++) begin
			m.start();
			sb({DEV_TYPE_DEF, 3'(k), 1'b0}, k == 5);
			m.stop();
		end
		m.start();
		sb({~DEV_TYPE_DEF, 3'h5, 1'b1}, 1'b0);
		m.stop();
		// A matching address with no start in front must go unanswered
		sb({DEV_TYPE_DEF, 3'h5, 1'b0}, 1'b0);
		sb(8'hFF, 1'b0);
		m.stop();
	endtask : t_decode

	task automatic t_page();
		cfg(2'h0, 1'b0, 2'h0, 1'b0);
		wr(3'h5, 13'h006, 10, 8'hA0);
		rd(3'h5, 13'h000, 4, 1'b1);
		rd(3'h5, 13'h004, 4, 1'b0);
		cfg(2'h1, 1'b0, 2'h0, 1'b0);
		wr(3'h5, 13'h01E, 3, 8'hC0);
		rd(3'h5, 13'h010, 16, 1'b1);
		cfg(2'h2, 1'b1, 2'h0, 1'b0);
		wr(3'h5, 13'h1E3E, 34, 8'h10);
		rd(3'h5, 13'h1E20, 32, 1'b1);
	endtask : t_page

	task automatic t_protect();
		cfg(2'h0, 1'b0, 2'h0, 1'b1);
		wr(3'h5, 13'h006, 1, 8'h77);
		cfg(2'h0, 1'b0, 2'h0, 1'b0);
		rd(3'h5, 13'h006, 1, 1'b1);
	endtask : t_protect

	task automatic t_psel();
		cfg(2'h0, 1'b0, 2'h2, 1'b0);
		wr(3'h4, 13'h040, 1, 8'h33);
		wr(3'h7, 13'h040, 1, 8'h5A);
		rd(3'h4, 13'h040, 1, 1'b1);
		rd(3'h7, 13'h040, 1, 1'b1);
		m.start();
		sb({DEV_TYPE_DEF, 3'h3, 1'b0}, 1'b0);
		m.stop();
	endtask : t_psel

	initial begin
		rstn = 1'b0;
		write_protect = 1'b0;
		device_select_bit0 = 1'b1;
		device_select_bit1 = 1'b0;
		device_select_bit2 = 1'b1;
		cfg_page_size = 2'h0;
		cfg_wide_addr = 1'b0;
		cfg_page_sel_cnt = 2'h0;
		repeat (5) @(posedge clk);
		@(negedge clk);
		rstn = 1'b1;
		repeat (6) @(negedge clk);
		t_decode();
		t_page();
		t_protect();
		t_psel();
		results();
	end

	// Whole run needs well under half of this span
	initial begin
		#1000000;
		miscompares++;
		results();
	end
endmodule : tb_sep_i2c_slave
